// >>> cae_exec.sv
// How it works
// - Add two registers plus carry, update Z C N V H, in one clock.
// - Word add or subtract of a constant updates Z C N V S in two clocks.
// - Subtract a register, with carry if asked, Z C N V H, in one clock.
// - Subtract a constant from a register, update Z C N V H, one clock.
// - Subtract a constant and carry from a register, five flags, one clock.
// - AND, OR and XOR with a register or constant set only Z N V, one clock.
// - Set bits by ORing a mask, clear by ANDing its complement, one clock.
// - The test leaves the register unchanged and updates Z N V in one clock.
// - Multiply unsigned, signed or mixed into R1:R0, Z and C, two clocks.
// - Fractional multiplies shift the product left by one into R1:R0.
// - The pointer jump loads the PC from Z, no flags, in two clocks.
// - The pointer call pushes the return and jumps to Z in three clocks.
// - Compare-skip skips the next instruction if equal, 1 to 3 clocks.
`timescale 1ns/1ps
module cae_exec (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic op_valid,
   input wire logic [4:0] op_code,
   input wire logic use_imm,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rd_hi_val,
   input wire logic [7:0] rr_val,
   input wire logic [7:0] imm,
   input wire logic [15:0] z_ptr,
   input wire logic next_long,
   output logic busy_r,
   output logic done_r,
   output logic wr_en_r,
   output logic wr_word_r,
   output logic wr_prod_r,
   output logic [15:0] wr_data_r,
   output logic push_en_r,
   output logic [7:0] sreg_r,
   output logic [15:0] pc_r
);
   cae_pkg::cae_st_e st_r, st_nxt;
   cae_pkg::cae_op_e op;
   logic [7:0] opb, r8, c_sreg, p_sreg_r, p_sreg_nxt, sreg_nxt;
   logic [15:0] c_wd, c_pc, wd_in, wk, w16, m_res;
   logic [15:0] p_wd_r, p_wd_nxt, p_pc_r, p_pc_nxt, pc_nxt, wr_data_nxt;
   logic [1:0] cyc;
   logic c_we, c_ww, c_wp, c_psh, m_sa, m_sb, m_fr, m_c, wsub;
   logic p_we_r, p_we_nxt, p_ww_r, p_ww_nxt, p_wp_r, p_wp_nxt;
   logic p_psh_r, p_psh_nxt, acc, commit, from_pend;
   logic busy_nxt, done_nxt, wr_en_nxt, wr_word_nxt, wr_prod_nxt, push_nxt;

   // Flags for byte add or subtract; S is not touched by these forms.
   function automatic logic [7:0] arith8(input logic [7:0] s,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] r,
      input logic sub);
      logic [7:0] o;
      logic [7:0] ae;
      logic [7:0] re;
      logic [7:0] cy;
      o = s;
      ae = sub ? ~a : a;
      re = sub ? r : ~r;
      cy = (ae & b) | ((ae | b) & re);
      o[cae_pkg::FLG_C] = cy[cae_pkg::B_MSB];
      o[cae_pkg::FLG_H] = cy[cae_pkg::B_NIB];
      o[cae_pkg::FLG_Z] = (r == 8'h00);
      o[cae_pkg::FLG_N] = r[cae_pkg::B_MSB];
      o[cae_pkg::FLG_V] = (a[cae_pkg::B_MSB] ^ r[cae_pkg::B_MSB]) &
         (sub ^ (a[cae_pkg::B_MSB] ~^ b[cae_pkg::B_MSB]));
      return o;
   endfunction : arith8

   // Flags for logic results: V cleared, Z and N from the result.
   function automatic logic [7:0] logic8(input logic [7:0] s,
      input logic [7:0] r);
      logic [7:0] o;
      o = s;
      o[cae_pkg::FLG_Z] = (r == 8'h00);
      o[cae_pkg::FLG_N] = r[cae_pkg::B_MSB];
      o[cae_pkg::FLG_V] = 1'b0;
      return o;
   endfunction : logic8

   assign op = cae_pkg::cae_op_e'(op_code);
   assign opb = use_imm ? imm : rr_val;
   assign wd_in = {rd_hi_val, rd_val};
   assign wk = {{(16 - cae_pkg::WIMM_W){1'b0}}, imm[cae_pkg::WIMM_W-1:0]};
   assign wsub = (op == cae_pkg::OP_WSUB);
   assign w16 = wsub ? wd_in - wk : wd_in + wk;
   // Multiplier controls follow the operation alone; kept apart from the
   // result process so that the product never loops back into it.
   assign m_sa = op inside {cae_pkg::OP_MULS, cae_pkg::OP_MIXMUL,
      cae_pkg::OP_FMULS, cae_pkg::OP_MIXFMUL};
   assign m_sb = op inside {cae_pkg::OP_MULS, cae_pkg::OP_FMULS};
   assign m_fr = op inside {cae_pkg::OP_FMUL, cae_pkg::OP_FMULS,
      cae_pkg::OP_MIXFMUL};

   cae_mul u_mul (
      .mul_a(rd_val),
      .mul_b(rr_val),
      .a_signed(m_sa),
      .b_signed(m_sb),
      .frac(m_fr),
      .mul_res(m_res),
      .mul_carry(m_c)
   );

   // Result, flags, program counter and length of the presented operation.
   always_comb
   begin
      r8 = 8'h00;
      c_sreg = sreg_r;
      c_wd = 16'h0000;
      c_pc = pc_r + cae_pkg::PC_STEP;
      c_we = 1'b0;
      c_ww = 1'b0;
      c_wp = 1'b0;
      c_psh = 1'b0;
      cyc = cae_pkg::CYC_ONE;
      case (op)
         cae_pkg::OP_ADD, cae_pkg::OP_ADC:
         begin
            r8 = rd_val + opb + {7'h00, (op == cae_pkg::OP_ADC) &
               sreg_r[cae_pkg::FLG_C]};
            c_sreg = arith8(sreg_r, rd_val, opb, r8, 1'b0);
            c_we = 1'b1;
         end
         cae_pkg::OP_SUB, cae_pkg::OP_SBC:
         begin
            // Immediate forms take the constant through opb.
            r8 = rd_val - opb - {7'h00, (op == cae_pkg::OP_SBC) &
               sreg_r[cae_pkg::FLG_C]};
            c_sreg = arith8(sreg_r, rd_val, opb, r8, 1'b1);
            c_we = 1'b1;
         end
         cae_pkg::OP_WADD, cae_pkg::OP_WSUB:
         begin
            c_wd = w16;
            c_ww = 1'b1;
            cyc = cae_pkg::CYC_TWO;
            c_sreg[cae_pkg::FLG_Z] = (w16 == 16'h0000);
            c_sreg[cae_pkg::FLG_N] = w16[cae_pkg::W_MSB];
            c_sreg[cae_pkg::FLG_V] = wsub ?
               wd_in[cae_pkg::W_MSB] & ~w16[cae_pkg::W_MSB] :
               ~wd_in[cae_pkg::W_MSB] & w16[cae_pkg::W_MSB];
            c_sreg[cae_pkg::FLG_C] = wsub ?
               w16[cae_pkg::W_MSB] & ~wd_in[cae_pkg::W_MSB] :
               wd_in[cae_pkg::W_MSB] & ~w16[cae_pkg::W_MSB];
            c_sreg[cae_pkg::FLG_S] = c_sreg[cae_pkg::FLG_N] ^
               c_sreg[cae_pkg::FLG_V];
         end
         cae_pkg::OP_AND, cae_pkg::OP_OR, cae_pkg::OP_EOR,
         cae_pkg::OP_SETB, cae_pkg::OP_CLRB:
         begin
            case (op)
               cae_pkg::OP_AND: r8 = rd_val & opb;
               cae_pkg::OP_EOR: r8 = rd_val ^ opb;
               cae_pkg::OP_CLRB: r8 = rd_val & ~imm;
               cae_pkg::OP_SETB: r8 = rd_val | imm;
               default: r8 = rd_val | opb;
            endcase
            c_sreg = logic8(sreg_r, r8);
            c_we = 1'b1;
         end
         cae_pkg::OP_ZMCHK:
         begin
            // Register stays as it is, so nothing is written back.
            c_sreg = logic8(sreg_r, rd_val & rd_val);
         end
         cae_pkg::OP_MUL, cae_pkg::OP_MULS, cae_pkg::OP_MIXMUL,
         cae_pkg::OP_FMUL, cae_pkg::OP_FMULS, cae_pkg::OP_MIXFMUL:
         begin
            c_wd = m_res;
            c_wp = 1'b1;
            cyc = cae_pkg::CYC_TWO;
            c_sreg[cae_pkg::FLG_Z] = (m_res == 16'h0000);
            c_sreg[cae_pkg::FLG_C] = m_c;
         end
         cae_pkg::OP_PJMP:
         begin
            c_pc = z_ptr;
            cyc = cae_pkg::CYC_TWO;
         end
         cae_pkg::OP_PCALL:
         begin
            // Return address rides on the write data bus with push_en_r.
            c_wd = pc_r + cae_pkg::PC_STEP;
            c_psh = 1'b1;
            c_pc = z_ptr;
            cyc = cae_pkg::CYC_THREE;
         end
         cae_pkg::OP_CSKIP:
         begin
            if (rd_val == rr_val)
            begin
               c_pc = pc_r + (next_long ? cae_pkg::SKIP_LONG :
                  cae_pkg::SKIP_SHORT);
               cyc = next_long ? cae_pkg::CYC_THREE : cae_pkg::CYC_TWO;
            end
         end
         default: c_we = 1'b0;
      endcase
   end

   // Sequencer: one-clock work commits at once, longer work is parked
   // in the pending set so that every output but busy_r changes on the last edge.
   always_comb
   begin
      acc = op_valid && (st_r == cae_pkg::ST_IDLE);
      from_pend = (st_r == cae_pkg::ST_LAST);
      commit = from_pend || (acc && (cyc == cae_pkg::CYC_ONE));
      st_nxt = st_r;
      p_we_nxt = p_we_r;
      p_ww_nxt = p_ww_r;
      p_wp_nxt = p_wp_r;
      p_psh_nxt = p_psh_r;
      p_wd_nxt = p_wd_r;
      p_pc_nxt = p_pc_r;
      p_sreg_nxt = p_sreg_r;
      case (st_r)
         cae_pkg::ST_IDLE:
         begin
            if (acc && (cyc != cae_pkg::CYC_ONE))
            begin
               st_nxt = (cyc == cae_pkg::CYC_TWO) ? cae_pkg::ST_LAST :
                  cae_pkg::ST_HOLD;
               p_we_nxt = c_we;
               p_ww_nxt = c_ww;
               p_wp_nxt = c_wp;
               p_psh_nxt = c_psh;
               p_wd_nxt = c_wd;
               p_pc_nxt = c_pc;
               p_sreg_nxt = c_sreg;
            end
         end
         cae_pkg::ST_HOLD: st_nxt = cae_pkg::ST_LAST;
         cae_pkg::ST_LAST: st_nxt = cae_pkg::ST_IDLE;
         default: st_nxt = cae_pkg::ST_IDLE;
      endcase
      busy_nxt = (st_nxt != cae_pkg::ST_IDLE);
      done_nxt = commit;
      // Write strobes are pulses; sreg and pc hold between commits.
      wr_en_nxt = commit && (from_pend ? p_we_r : c_we);
      wr_word_nxt = commit && (from_pend ? p_ww_r : c_ww);
      wr_prod_nxt = commit && (from_pend ? p_wp_r : c_wp);
      push_nxt = commit && (from_pend ? p_psh_r : c_psh);
      wr_data_nxt = wr_data_r;
      sreg_nxt = sreg_r;
      pc_nxt = pc_r;
      if (commit)
      begin
         wr_data_nxt = from_pend ? p_wd_r : (c_we ? {8'h00, r8} : c_wd);
         sreg_nxt = from_pend ? p_sreg_r : c_sreg;
         pc_nxt = from_pend ? p_pc_r : c_pc;
      end
   end

   // State registers.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_r <= cae_pkg::ST_IDLE;
         p_we_r <= 1'b0;
         p_ww_r <= 1'b0;
         p_wp_r <= 1'b0;
         p_psh_r <= 1'b0;
         p_wd_r <= 16'h0000;
         p_pc_r <= cae_pkg::PC_RST;
         p_sreg_r <= cae_pkg::SREG_RST;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         wr_en_r <= 1'b0;
         wr_word_r <= 1'b0;
         wr_prod_r <= 1'b0;
         push_en_r <= 1'b0;
         wr_data_r <= 16'h0000;
         sreg_r <= cae_pkg::SREG_RST;
         pc_r <= cae_pkg::PC_RST;
      end
      else
      begin
         st_r <= st_nxt;
         p_we_r <= p_we_nxt;
         p_ww_r <= p_ww_nxt;
         p_wp_r <= p_wp_nxt;
         p_psh_r <= p_psh_nxt;
         p_wd_r <= p_wd_nxt;
         p_pc_r <= p_pc_nxt;
         p_sreg_r <= p_sreg_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         wr_en_r <= wr_en_nxt;
         wr_word_r <= wr_word_nxt;
         wr_prod_r <= wr_prod_nxt;
         push_en_r <= push_nxt;
         wr_data_r <= wr_data_nxt;
         sreg_r <= sreg_nxt;
         pc_r <= pc_nxt;
      end
   end

   // Checks on the committed results and their timing.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence two_clk_s;
      busy_r && !done_r ##1 done_r && !busy_r;
   endsequence
   sequence three_clk_s;
      busy_r && !done_r ##1 busy_r && !done_r ##1 done_r && !busy_r;
   endsequence

   add_one_clk_a: assert property (acc && op == cae_pkg::OP_ADD |=>
      done_r && wr_en_r && !busy_r &&
      wr_data_r[7:0] == $past(rd_val) + $past(opb))
      else $error("add result or timing wrong");
   word_two_clk_a: assert property (acc && wsub |=>
      two_clk_s ##0 wr_word_r && wr_data_r == $past(w16, 2))
      else $error("word subtract not done in two clocks");
   sub_borrow_a: assert property (acc && op == cae_pkg::OP_SUB &&
      rr_val > rd_val && !use_imm |=> sreg_r[cae_pkg::FLG_C])
      else $error("subtract borrow not flagged");
   logic_v_clear_a: assert property (acc &&
      op inside {cae_pkg::OP_AND, cae_pkg::OP_OR, cae_pkg::OP_EOR} |=>
      !sreg_r[cae_pkg::FLG_V] &&
      $stable(sreg_r[cae_pkg::FLG_C]) && $stable(sreg_r[cae_pkg::FLG_H]))
      else $error("logic flags wrong");
   clear_bits_a: assert property (acc && op == cae_pkg::OP_CLRB |=>
      wr_data_r[7:0] == ($past(rd_val) & ~$past(imm)))
      else $error("bit clear result wrong");
   test_no_write_a: assert property (acc &&
      op == cae_pkg::OP_ZMCHK |=> done_r && !wr_en_r &&
      sreg_r[cae_pkg::FLG_Z] == ($past(rd_val) == 8'h00))
      else $error("test wrote a register or bad Z");
   mul_two_clk_a: assert property (acc && op == cae_pkg::OP_MUL |=>
      two_clk_s ##0 wr_prod_r &&
      wr_data_r == $past(rd_val, 2) * $past(rr_val, 2))
      else $error("multiply product or timing wrong");
   jump_pointer_a: assert property (acc && op == cae_pkg::OP_PJMP |=>
      two_clk_s ##0 pc_r == $past(z_ptr, 2) && $stable(sreg_r))
      else $error("pointer jump wrong");
   call_push_a: assert property (acc && op == cae_pkg::OP_PCALL |=>
      three_clk_s ##0 push_en_r &&
      wr_data_r == $past(pc_r, 3) + cae_pkg::PC_STEP)
      else $error("pointer call push wrong");
   skip_miss_a: assert property (acc && op == cae_pkg::OP_CSKIP &&
      rd_val != rr_val |=> done_r && pc_r == $past(pc_r) + cae_pkg::PC_STEP)
      else $error("compare skip miss wrong");
endmodule : cae_exec

// >>> cae_mul.sv
`timescale 1ns/1ps
// Signed or unsigned 8x8 multiplier with optional fractional shift.
module cae_mul (
   input wire logic [7:0] mul_a,
   input wire logic [7:0] mul_b,
   input wire logic a_signed,
   input wire logic b_signed,
   input wire logic frac,
   output logic [15:0] mul_res,
   output logic mul_carry
);
   logic signed [8:0] ext_a;
   logic signed [8:0] ext_b;
   logic signed [17:0] full;
   logic [15:0] raw;

   // A ninth bit carries the sign, so one signed product covers all forms.
   assign ext_a = {a_signed & mul_a[cae_pkg::B_MSB], mul_a};
   assign ext_b = {b_signed & mul_b[cae_pkg::B_MSB], mul_b};
   assign full = 18'(ext_a) * 18'(ext_b);
   assign raw = full[15:0];
   // Carry is taken from the product before the fractional shift.
   assign mul_carry = raw[cae_pkg::W_MSB];
   assign mul_res = frac ? {raw[14:0], 1'b0} : raw;
endmodule : cae_mul

// >>> cae_pkg.sv
package cae_pkg;
   // Status register bit positions.
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   // Operand bit positions used by the flag logic, and the width of the word constant.
   localparam int B_MSB = 7;
   localparam int B_NIB = 3;
   localparam int W_MSB = 15;
   localparam int WIMM_W = 6;
   // Reset values.
   localparam logic [7:0] SREG_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   // Program counter steps, in instruction words.
   localparam logic [15:0] PC_STEP = 16'h0001;
   localparam logic [15:0] SKIP_SHORT = 16'h0002;
   localparam logic [15:0] SKIP_LONG = 16'h0003;
   // Execution lengths in clocks.
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   // Operations presented by the decoder.
   typedef enum logic [4:0] {
      OP_ADD = 5'h00, OP_ADC = 5'h01, OP_SUB = 5'h02, OP_SBC = 5'h03,
      OP_WADD = 5'h04, OP_WSUB = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
      OP_EOR = 5'h08, OP_SETB = 5'h09, OP_CLRB = 5'h0A, OP_ZMCHK = 5'h0B,
      OP_MUL = 5'h0C, OP_MULS = 5'h0D, OP_MIXMUL = 5'h0E, OP_FMUL = 5'h0F,
      OP_FMULS = 5'h10, OP_MIXFMUL = 5'h11, OP_PJMP = 5'h12,
      OP_PCALL = 5'h13, OP_CSKIP = 5'h14
   } cae_op_e;
   // Sequencer states, Gray coded along idle, hold, last.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01,
      ST_LAST = 2'b11
   } cae_st_e;
endpackage : cae_pkg

// >>> cae_rf_model.sv
`timescale 1ns/1ps
// Register file and stack sink that sits behind the datapath.
module cae_rf_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wr_en_r,
   input wire logic wr_word_r,
   input wire logic wr_prod_r,
   input wire logic push_en_r,
   input wire logic [15:0] wr_data_r,
   output logic [7:0] push_cnt,
   output logic [15:0] stack_top,
   output logic [15:0] prod_q,
   output logic [15:0] pair_q
);
   // Writes land on the edge after the pulse, as a real file would.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         push_cnt <= 8'h00;
         stack_top <= 16'h0000;
      end
      else if (push_en_r)
      begin
         push_cnt <= push_cnt + 8'h01;
         stack_top <= wr_data_r;
      end
      if (wr_prod_r)
         prod_q <= wr_data_r;
      if (wr_word_r)
         pair_q <= wr_data_r;
      else if (wr_en_r)
         pair_q[7:0] <= wr_data_r[7:0];
   end
endmodule : cae_rf_model

// >>> cpu_arith_logic_branch_exec_tb.sv
`timescale 1ns/1ps
// Self-checking bench: a driver notes each result, a monitor checks it.
module cpu_arith_logic_branch_exec_tb;
   typedef struct {
      logic [3:0] wr;
      logic [15:0] data;
      logic [7:0] sreg;
      logic [15:0] pc;
      int at;
   } cae_exp_s;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic op_valid = 1'b0;
   logic [4:0] op_code = 5'h00;
   logic use_imm = 1'b0;
   logic [7:0] rd_val = 8'h00;
   logic [7:0] rd_hi_val = 8'h00;
   logic [7:0] rr_val = 8'h00;
   logic [7:0] imm = 8'h00;
   logic [15:0] z_ptr = 16'h0000;
   logic next_long = 1'b0;
   logic busy_r, done_r, wr_en_r, wr_word_r, wr_prod_r, push_en_r;
   logic [15:0] wr_data_r, pc_r, stack_top, last_ret;
   logic [7:0] sreg_r, push_cnt, exp_sreg;
   logic [15:0] exp_pc;
   logic [15:0] prod_q, pair_q, last_prod, last_pair;
   int bad_count = 0;
   int total_checks = 0;
   int cnt = 0;
   int pushes = 0;
   int seed = 32'h21266A10;
   cae_exp_s exp_q[$];
   cae_exp_s got;
   cae_exec u_cae_exec (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
      .op_code(op_code), .use_imm(use_imm), .rd_val(rd_val),
      .rd_hi_val(rd_hi_val), .rr_val(rr_val), .imm(imm), .z_ptr(z_ptr),
      .next_long(next_long), .busy_r(busy_r), .done_r(done_r),
      .wr_en_r(wr_en_r), .wr_word_r(wr_word_r), .wr_prod_r(wr_prod_r),
      .wr_data_r(wr_data_r), .push_en_r(push_en_r), .sreg_r(sreg_r),
      .pc_r(pc_r));
   cae_rf_model u_cae_rf_model (.clk(clk), .sys_rst(sys_rst),
      .wr_en_r(wr_en_r), .wr_word_r(wr_word_r), .wr_prod_r(wr_prod_r),
      .push_en_r(push_en_r), .wr_data_r(wr_data_r), .push_cnt(push_cnt),
      .stack_top(stack_top), .prod_q(prod_q), .pair_q(pair_q));
   // Free-running core clock, 25 ns period.
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   // Edge counter that dates every result.
   always @(posedge clk) cnt <= cnt + 1;
   task automatic chk(input string what, input logic [15:0] e,
      input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic end_of_test;
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // Works out the commit from the inputs, the flags and the pc held.
   task automatic predict(output cae_exp_s e, output int n);
      logic [8:0] s9;
      logic [4:0] h5;
      logic [16:0] w;
      logic [15:0] a, b16;
      logic [7:0] b, r;
      logic fc, fz, fn, fv, fs, fh, cin, sb, sa, bs;
      int k;
      fc = exp_sreg[cae_pkg::FLG_C];
      fz = exp_sreg[cae_pkg::FLG_Z];
      fn = exp_sreg[cae_pkg::FLG_N];
      fv = exp_sreg[cae_pkg::FLG_V];
      fs = exp_sreg[cae_pkg::FLG_S];
      fh = exp_sreg[cae_pkg::FLG_H];
      b = use_imm ? imm : rr_val;
      cin = fc & op_code[0];
      n = 1;
      e.wr = 4'h0;
      e.data = 16'h0000;
      e.pc = exp_pc + cae_pkg::PC_STEP;
      k = int'(op_code);
      if (k < 4)
      begin
         sb = op_code[1];
         s9 = sb ? {1'b0, rd_val} - b - cin : {1'b0, rd_val} + b + cin;
         h5 = sb ? {1'b0, rd_val[3:0]} - b[3:0] - cin
                 : {1'b0, rd_val[3:0]} + b[3:0] + cin;
         r = s9[7:0];
         fc = s9[8];
         fh = h5[4];
         fv = (sb ^ ~(rd_val[7] ^ b[7])) & (rd_val[7] ^ r[7]);
         fz = (r == 8'h00);
         fn = r[7];
         e.wr = 4'h8;
         e.data = {8'h00, r};
      end
      else if (k < 6)
      begin
         a = {rd_hi_val, rd_val};
         w = op_code[0] ? {1'b0, a} - imm[5:0] : {1'b0, a} + imm[5:0];
         fc = w[16];
         fn = w[15];
         fz = (w[15:0] == 16'h0000);
         fv = op_code[0] ? a[15] & ~w[15] : ~a[15] & w[15];
         fs = fn ^ fv;
         e.wr = 4'h4;
         e.data = w[15:0];
         n = 2;
      end
      else if (k < 12)
      begin
         case (k)
            6: r = rd_val & b;
            7: r = rd_val | b;
            8: r = rd_val ^ b;
            9: r = rd_val | imm;
            10: r = rd_val & ~imm;
            default: r = rd_val;
         endcase
         fz = (r == 8'h00);
         fn = r[7];
         fv = 1'b0;
         e.wr = (k == 11) ? 4'h0 : 4'h8;
         e.data = {8'h00, r};
      end
      else if (k < 18)
      begin
         sa = (k % 3) != 0;
         bs = (k % 3) == 1;
         a = {{8{sa & rd_val[7]}}, rd_val};
         b16 = {{8{bs & rr_val[7]}}, rr_val};
         w = {1'b0, a * b16};
         fc = w[15];
         if (k > 14)
            w = w << 1;
         fz = (w[15:0] == 16'h0000);
         e.wr = 4'h2;
         e.data = w[15:0];
         n = 2;
      end
      else if (k == 18 || k == 19)
      begin
         e.pc = z_ptr;
         n = k - 16;
         e.wr = (k == 19) ? 4'h1 : 4'h0;
         e.data = (k == 19) ? exp_pc + cae_pkg::PC_STEP : 16'h0000;
      end
      else if (k == 20 && rd_val == rr_val)
      begin
         n = next_long ? 3 : 2;
         e.pc = exp_pc + (next_long ? cae_pkg::SKIP_LONG
                                    : cae_pkg::SKIP_SHORT);
      end
      exp_sreg[cae_pkg::FLG_C] = fc;
      exp_sreg[cae_pkg::FLG_Z] = fz;
      exp_sreg[cae_pkg::FLG_N] = fn;
      exp_sreg[cae_pkg::FLG_V] = fv;
      exp_sreg[cae_pkg::FLG_S] = fs;
      exp_sreg[cae_pkg::FLG_H] = fh;
      e.sreg = exp_sreg;
      exp_pc = e.pc;
   endtask : predict
   // Presents one operation; junk is offered while it is in flight.
   // Called and left at a falling edge, so no input moves on a rising one.
   task automatic issue(input logic [4:0] op);
      cae_exp_s e;
      int n;
      op_code = op;
      op_valid = 1'b1;
      predict(e, n);
      e.at = cnt + n;
      exp_q.push_back(e);
      if (e.wr == 4'h1)
         pushes++;
      if (e.wr == 4'h1)
         last_ret = e.data;
      @(posedge clk);
      if (n > 1)
      begin
         @(negedge clk);
         op_code = 5'($random(seed));
         rd_val = 8'($random(seed));
         repeat (n - 1) @(posedge clk);
      end
      @(negedge clk);
   endtask : issue
   task automatic rnd(input logic eq);
      use_imm = 1'($random(seed));
      rd_val = 8'($random(seed));
      rd_hi_val = 8'($random(seed));
      rr_val = eq ? rd_val : 8'($random(seed));
      imm = 8'($random(seed));
      z_ptr = 16'($random(seed));
      next_long = 1'($random(seed));
   endtask : rnd
   task automatic dir(input logic [4:0] op, input logic [7:0] d,
      input logic [7:0] s, input logic ui);
      rnd(1'b0);
      rd_val = d;
      rd_hi_val = 8'h00;
      rr_val = s;
      imm = s;
      use_imm = ui;
      issue(op);
   endtask : dir
   task automatic reset_check;
      chk("pc after reset", cae_pkg::PC_RST, pc_r);
      chk("sreg after reset", {8'h00, cae_pkg::SREG_RST}, {8'h00, sreg_r});
      chk("busy after reset", 16'h0000, {15'h0000, busy_r});
      exp_pc = cae_pkg::PC_RST;
      exp_sreg = cae_pkg::SREG_RST;
   endtask : reset_check
   // Monitor: each done pulse takes the oldest note and compares.
   always @(negedge clk)
   begin
      if (done_r === 1'b1 && exp_q.size() == 0)
         chk("spare done", 16'h0000, 16'h0001);
      else if (done_r === 1'b1)
      begin
         got = exp_q.pop_front();
         chk("strobes", {12'h000, got.wr}, {12'h000, wr_en_r, wr_word_r,
            wr_prod_r, push_en_r});
         chk("clock count", 16'(got.at), 16'(cnt));
         chk("status", {8'h00, got.sreg}, {8'h00, sreg_r});
         chk("pc", got.pc, pc_r);
         if (got.wr == 4'h8)
            chk("byte", got.data, {8'h00, wr_data_r[7:0]});
         else if (got.wr != 4'h0)
            chk("word", got.data, wr_data_r);
         // Shadow of what the register file should now hold.
         if (got.wr == 4'h2)
            last_prod = got.data;
         if (got.wr == 4'h4)
            last_pair = got.data;
         else if (got.wr == 4'h8)
            last_pair[7:0] = got.data[7:0];
      end
      else if (sys_rst === 1'b0)
         chk("stray strobes", 16'h0000, {12'h000, wr_en_r, wr_word_r,
            wr_prod_r, push_en_r});
   end
   initial
   begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      reset_check();
      dir(5'h00, 8'hFF, 8'h01, 1'b0);
      dir(5'h01, 8'h7F, 8'h00, 1'b0);
      dir(5'h02, 8'h00, 8'h01, 1'b1);
      dir(5'h03, 8'h80, 8'h00, 1'b1);
      dir(5'h05, 8'h00, 8'h01, 1'b0);
      dir(5'h0C, 8'hFF, 8'hFF, 1'b0);
      dir(5'h10, 8'h80, 8'h80, 1'b0);
      for (int rep = 0; rep < 40; rep++)
         for (int op = 0; op < 32; op++)
         begin
            rnd(1'($random(seed)));
            issue(5'(op));
         end
      op_valid = 1'b0;
      repeat (4) @(negedge clk);
      chk("pushes", 16'(pushes), {8'h00, push_cnt});
      chk("return address", last_ret, stack_top);
      chk("product pair", last_prod, prod_q);
      chk("register pair", last_pair, pair_q);
      sys_rst = 1'b1;
      @(negedge clk);
      sys_rst = 1'b0;
      reset_check();
      for (int op = 18; op < 21; op++)
      begin
         rnd(1'b1);
         issue(5'(op));
      end
      op_valid = 1'b0;
      repeat (4) @(negedge clk);
      chk("notes left", 16'h0000, 16'(exp_q.size()));
      end_of_test();
   end
   // Watchdog well beyond the two thousand or fewer cycles the run needs.
   initial
   begin
      #500000;
      bad_count++;
      end_of_test();
   end
endmodule : cpu_arith_logic_branch_exec_tb
